/* File: codec_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module codec_ctrl_chk (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_hit,
  input wire logic [1:0] line_play_gain,
  input wire logic [5:0] line_capture_gain,
  input wire logic [5:0] mic_capture_gain,
  input wire logic       line_input_second,
  input wire logic       line_adc_second,
  input wire logic       mic_amplifier_on,
  input wire logic       mic_supply_on,
  input wire logic [7:0] reference_trim_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ------------------------------
  // Register write effects and volume register read-back
  // ------------------------------
  AST_LINE_PLAY: assert property (
    sfr_wr && sfr_addr == 8'hBB |=> line_play_gain == $past(sfr_wdata[7:6]))
    else $error("line playback gain not taken from write");
  // Override clear is inferred from the current capture code
  AST_LINE_CAP: assert property (
    sfr_wr && sfr_addr == 8'hBB && line_capture_gain != 6'h04
    |=> line_capture_gain == ($past(sfr_wdata[3]) ? 6'h02 : 6'h01))
    else $error("line capture gain wrong without override");
  AST_LINE_OVR: assert property (
    sfr_wr && sfr_addr == 8'hC7 && sfr_wdata[5] |=> line_capture_gain == 6'h04)
    else $error("line override did not give top gain");
  AST_MIC_OVR: assert property (
    sfr_wr && sfr_addr == 8'hC7 && sfr_wdata[1] |=> mic_capture_gain == 6'h01)
    else $error("mic override did not give low gain");
  AST_SELECT: assert property (
    sfr_wr && sfr_addr == 8'hC7 |=> line_input_second == $past(sfr_wdata[4])
    && line_adc_second == line_input_second && mic_amplifier_on == $past(sfr_wdata[2]))
    else $error("gain select outputs not taken from write");
  AST_SUPPLY: assert property (
    sfr_wr && sfr_addr == 8'hD0 |=> mic_supply_on == $past(sfr_wdata[4]))
    else $error("mic supply not taken from mode bit");
  AST_TRIM: assert property (
    sfr_wr && sfr_addr == 8'hBA |=> reference_trim_code == $past(sfr_wdata))
    else $error("trim code not taken from write");
  AST_HOLD: assert property (
    !sfr_wr |=> $stable(reference_trim_code) && $stable(line_play_gain))
    else $error("control output moved without a write");
  AST_SPARE: assert property (
    sfr_rd && (sfr_addr == 8'hBB || sfr_addr == 8'hBC)
    |=> sfr_hit && (sfr_rdata & 8'h37) == 8'h00)
    else $error("volume spare bits read nonzero");
  cover property (sfr_wr && sfr_addr == 8'hC7 && sfr_wdata[1]);
  cover property (sfr_rd ##1 !sfr_hit);
  cover property (sfr_wr && sfr_addr == 8'hBB);
endmodule : codec_ctrl_chk
bind codec_gain_and_vref_control codec_ctrl_chk chk_i (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
  .line_play_gain(line_play_gain), .line_capture_gain(line_capture_gain),
  .mic_capture_gain(mic_capture_gain), .line_input_second(line_input_second),
  .line_adc_second(line_adc_second), .mic_amplifier_on(mic_amplifier_on),
  .mic_supply_on(mic_supply_on), .reference_trim_code(reference_trim_code));
`default_nettype wire

/* File: codec_ctrl_pkg.sv */
package codec_ctrl_pkg;

  // ----------------------------------------
  // Special-function register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_REFERENCE_TRIM     = 8'hBA;
  localparam logic [7:0] ADDR_LINE_CODEC_VOLUME  = 8'hBB;
  localparam logic [7:0] ADDR_MIC_CODEC_VOLUME   = 8'hBC;
  localparam logic [7:0] ADDR_CODEC_GAIN_SELECT  = 8'hC7;
  localparam logic [7:0] ADDR_SYSTEM_MODE        = 8'hD0;
  localparam logic [7:0] ADDR_AUX_OUTPUT_LEVEL   = 8'hD1;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_REFERENCE_TRIM      = 8'hA0;
  localparam logic [7:0] RST_VOLUME              = 8'h00;
  localparam logic [7:0] RST_CODEC_GAIN_SELECT   = 8'h00;
  localparam logic [7:0] RST_SYSTEM_MODE         = 8'h00;
  localparam logic [7:0] RST_AUX_OUTPUT_LEVEL    = 8'h00;

  // ----------------------------------------
  // Writable bit masks and field positions
  // ----------------------------------------
  localparam logic [7:0] VOLUME_MASK             = 8'hC8;
  localparam logic [7:0] GAIN_SELECT_MASK        = 8'h36;
  localparam int         VOL_PLAY_HI             = 7;
  localparam int         VOL_PLAY_LO             = 6;
  localparam int         VOL_CAPTURE_BIT         = 3;
  localparam int         GS_LINE_HIGH_GAIN_BIT   = 5;
  localparam int         GS_LINE_INPUT_SEL_BIT   = 4;
  localparam int         GS_MIC_AMP_ENABLE_BIT   = 2;
  localparam int         GS_MIC_LOW_GAIN_BIT     = 1;
  localparam int         SM_LINE_ANALOG_BIT      = 0;
  localparam int         SM_LINE_DIGITAL_BIT     = 1;
  localparam int         SM_MIC_ANALOG_BIT       = 2;
  localparam int         SM_MIC_DIGITAL_BIT      = 3;
  localparam int         SM_MIC_SUPPLY_BIT       = 4;

  // ----------------------------------------
  // Playback gain codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PLAY_M12DB = 2'h0,
    PLAY_M6DB  = 2'h1,
    PLAY_0DB   = 2'h2,
    PLAY_P6DB  = 2'h3
  } play_gain_t;

  // ----------------------------------------
  // Capture gain steps, one-hot
  // ----------------------------------------
  typedef enum logic [5:0] {
    CAP_7DB  = 6'h01,
    CAP_23DB = 6'h02,
    CAP_35DB = 6'h04,
    CAP_38DB = 6'h08,
    CAP_50DB = 6'h10,
    CAP_NONE = 6'h20
  } capture_gain_t;

endpackage : codec_ctrl_pkg

/* File: codec_gain_and_vref_control.sv */
`timescale 1ns/1ps
`default_nettype none

module codec_gain_and_vref_control (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_hit,
  output logic      [1:0] line_play_gain,
  output logic      [1:0] mic_play_gain,
  output logic      [5:0] line_capture_gain,
  output logic      [5:0] mic_capture_gain,
  output logic            line_input_second,
  output logic            line_adc_second,
  output logic            mic_amplifier_on,
  output logic            line_analog_enable,
  output logic            line_digital_enable,
  output logic            mic_analog_enable,
  output logic            mic_digital_enable,
  output logic            mic_supply_on,
  output logic      [7:0] reference_trim_code,
  output logic      [7:0] aux_output_code
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] reference_trim;
    logic [7:0] line_codec_volume;
    logic [7:0] mic_codec_volume;
    logic [7:0] codec_gain_select;
    logic [7:0] system_mode;
    logic [7:0] aux_output_level;
    logic [7:0] rdata;
    logic       hit;
    logic [5:0] line_cap;
    logic [5:0] mic_cap;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ----------------------------------------
  // Gain decode
  // ----------------------------------------
  function automatic logic [5:0] line_capture(input logic [7:0] vol, input logic [7:0] gs);
    logic [5:0] g;
    g = 6'h00;
    if (gs[codec_ctrl_pkg::GS_LINE_HIGH_GAIN_BIT]) begin
      g = codec_ctrl_pkg::CAP_35DB;
    end else if (vol[codec_ctrl_pkg::VOL_CAPTURE_BIT]) begin
      g = codec_ctrl_pkg::CAP_23DB;
    end else begin
      g = codec_ctrl_pkg::CAP_7DB;
    end
    return g;
  endfunction : line_capture

  function automatic logic [5:0] mic_capture(input logic [7:0] vol, input logic [7:0] gs);
    logic [5:0] g;
    logic       hi;
    logic       amp;
    g   = 6'h00;
    hi  = vol[codec_ctrl_pkg::VOL_CAPTURE_BIT];
    amp = gs[codec_ctrl_pkg::GS_MIC_AMP_ENABLE_BIT];
    if (gs[codec_ctrl_pkg::GS_MIC_LOW_GAIN_BIT]) begin
      g = codec_ctrl_pkg::CAP_7DB;
    end else if (amp) begin
      g = hi ? codec_ctrl_pkg::CAP_50DB : codec_ctrl_pkg::CAP_38DB;
    end else begin
      g = hi ? codec_ctrl_pkg::CAP_35DB : codec_ctrl_pkg::CAP_23DB;
    end
    return g;
  endfunction : mic_capture

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (sfr_wr) begin
      unique case (sfr_addr)
        codec_ctrl_pkg::ADDR_REFERENCE_TRIM: begin
          st_nxt.reference_trim = sfr_wdata;
        end
        codec_ctrl_pkg::ADDR_LINE_CODEC_VOLUME: begin
          st_nxt.line_codec_volume =
            sfr_wdata & codec_ctrl_pkg::VOLUME_MASK;
        end
        codec_ctrl_pkg::ADDR_MIC_CODEC_VOLUME: begin
          st_nxt.mic_codec_volume = sfr_wdata & codec_ctrl_pkg::VOLUME_MASK;
        end
        codec_ctrl_pkg::ADDR_CODEC_GAIN_SELECT: begin
          st_nxt.codec_gain_select =
            sfr_wdata & codec_ctrl_pkg::GAIN_SELECT_MASK;
        end
        codec_ctrl_pkg::ADDR_SYSTEM_MODE: begin
          st_nxt.system_mode = sfr_wdata;
        end
        codec_ctrl_pkg::ADDR_AUX_OUTPUT_LEVEL: begin
          st_nxt.aux_output_level = sfr_wdata;
        end
        default: begin
        end
      endcase
    end
    // Read data is registered; unmapped addresses read zero and drop hit
    st_nxt.hit   = 1'b0;
    st_nxt.rdata = 8'h00;
    if (sfr_rd) begin
      st_nxt.hit = 1'b1;
      unique case (sfr_addr)
        codec_ctrl_pkg::ADDR_REFERENCE_TRIM:    st_nxt.rdata = st_r.reference_trim;
        codec_ctrl_pkg::ADDR_LINE_CODEC_VOLUME: st_nxt.rdata = st_r.line_codec_volume;
        codec_ctrl_pkg::ADDR_MIC_CODEC_VOLUME:  st_nxt.rdata = st_r.mic_codec_volume;
        codec_ctrl_pkg::ADDR_CODEC_GAIN_SELECT: st_nxt.rdata = st_r.codec_gain_select;
        codec_ctrl_pkg::ADDR_SYSTEM_MODE:       st_nxt.rdata = st_r.system_mode;
        codec_ctrl_pkg::ADDR_AUX_OUTPUT_LEVEL:  st_nxt.rdata = st_r.aux_output_level;
        default: begin
          st_nxt.hit = 1'b0;
        end
      endcase
    end
    // Decode from the next register values so gains track writes without extra lag
    st_nxt.line_cap = line_capture(st_nxt.line_codec_volume, st_nxt.codec_gain_select);
    st_nxt.mic_cap  = mic_capture(st_nxt.mic_codec_volume, st_nxt.codec_gain_select);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r.reference_trim    <= codec_ctrl_pkg::RST_REFERENCE_TRIM;
      st_r.line_codec_volume <= codec_ctrl_pkg::RST_VOLUME;
      st_r.mic_codec_volume  <= codec_ctrl_pkg::RST_VOLUME;
      st_r.codec_gain_select <= codec_ctrl_pkg::RST_CODEC_GAIN_SELECT;
      st_r.system_mode       <= codec_ctrl_pkg::RST_SYSTEM_MODE;
      st_r.aux_output_level  <= codec_ctrl_pkg::RST_AUX_OUTPUT_LEVEL;
      st_r.rdata             <= 8'h00;
      st_r.hit               <= 1'b0;
      st_r.line_cap          <= codec_ctrl_pkg::CAP_7DB;
      st_r.mic_cap           <= codec_ctrl_pkg::CAP_23DB;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------
  assign sfr_rdata           = st_r.rdata;
  assign sfr_hit             = st_r.hit;
  assign line_play_gain      =
    st_r.line_codec_volume[codec_ctrl_pkg::VOL_PLAY_HI:codec_ctrl_pkg::VOL_PLAY_LO];
  assign mic_play_gain       =
    st_r.mic_codec_volume[codec_ctrl_pkg::VOL_PLAY_HI:codec_ctrl_pkg::VOL_PLAY_LO];
  assign line_capture_gain   = st_r.line_cap;
  assign mic_capture_gain    = st_r.mic_cap;
  assign line_input_second   =
    st_r.codec_gain_select[codec_ctrl_pkg::GS_LINE_INPUT_SEL_BIT];
  assign line_adc_second     =
    st_r.codec_gain_select[codec_ctrl_pkg::GS_LINE_INPUT_SEL_BIT];
  assign mic_amplifier_on    = st_r.codec_gain_select[codec_ctrl_pkg::GS_MIC_AMP_ENABLE_BIT];
  assign line_analog_enable  = st_r.system_mode[codec_ctrl_pkg::SM_LINE_ANALOG_BIT];
  assign line_digital_enable = st_r.system_mode[codec_ctrl_pkg::SM_LINE_DIGITAL_BIT];
  assign mic_analog_enable   = st_r.system_mode[codec_ctrl_pkg::SM_MIC_ANALOG_BIT];
  assign mic_digital_enable  = st_r.system_mode[codec_ctrl_pkg::SM_MIC_DIGITAL_BIT];
  assign mic_supply_on       = st_r.system_mode[codec_ctrl_pkg::SM_MIC_SUPPLY_BIT];
  // Trim code goes to the source as is; a larger code lowers the reference
  assign reference_trim_code = st_r.reference_trim;
  assign aux_output_code     = st_r.aux_output_level;

endmodule : codec_gain_and_vref_control

`default_nettype wire

/* File: codec_gain_and_vref_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module codec_gain_and_vref_control_test;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_rdata, reference_trim_code, aux_output_code;
  logic [1:0] line_play_gain, mic_play_gain;
  logic [5:0] line_capture_gain, mic_capture_gain;
  logic       sfr_hit, line_input_second, line_adc_second, mic_amplifier_on, mic_supply_on;
  logic       line_analog_enable, line_digital_enable, mic_analog_enable, mic_digital_enable;
  int         err_total = 0;
  int         n_checks = 0;
  logic [7:0] m [0:6];
  logic [7:0] adr [0:6] = '{8'hBA, 8'hBB, 8'hBC, 8'hC7, 8'hD0, 8'hD1, 8'h55};
  logic [7:0] msk [0:6] = '{8'hFF, 8'hC8, 8'hC8, 8'h36, 8'hFF, 8'hFF, 8'h00};
  wire  [4:0] mode_seen = {mic_supply_on, mic_digital_enable, mic_analog_enable,
                           line_digital_enable, line_analog_enable};
  codec_gain_and_vref_control uut (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .line_play_gain(line_play_gain), .mic_play_gain(mic_play_gain),
    .line_capture_gain(line_capture_gain), .mic_capture_gain(mic_capture_gain),
    .line_input_second(line_input_second), .line_adc_second(line_adc_second),
    .mic_amplifier_on(mic_amplifier_on), .line_analog_enable(line_analog_enable),
    .line_digital_enable(line_digital_enable), .mic_analog_enable(mic_analog_enable),
    .mic_digital_enable(mic_digital_enable), .mic_supply_on(mic_supply_on),
    .reference_trim_code(reference_trim_code), .aux_output_code(aux_output_code));
  initial forever #12.5 clk = ~clk;
  // ------------------------------
  // Expectation helpers and bus tasks
  // ------------------------------
  function automatic logic [5:0] cap_line(input logic [7:0] v, input logic [7:0] g);
    return g[5] ? 6'h04 : (v[3] ? 6'h02 : 6'h01);
  endfunction : cap_line
  function automatic logic [5:0] cap_mic(input logic [7:0] v, input logic [7:0] g);
    if (g[1]) return 6'h01;
    return v[3] ? (g[2] ? 6'h10 : 6'h04) : (g[2] ? 6'h08 : 6'h02);
  endfunction : cap_mic
  task automatic stop_test();
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input int i, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= adr[i];
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    m[i] = d & msk[i];
  endtask : wr
  task automatic rd(input int i);
    @(posedge clk);
    sfr_addr <= adr[i];
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(negedge clk);
    chk("rdata", {8'h00, m[i]}, {8'h00, sfr_rdata});
    chk("hit", {15'h0000, i != 6}, {15'h0000, sfr_hit});
  endtask : rd
  task automatic outs();
    @(negedge clk);
    chk("play", {12'h000, m[1][7:6], m[2][7:6]},
        {12'h000, line_play_gain, mic_play_gain});
    chk("line_cap", {10'h000, cap_line(m[1], m[3])},
        {10'h000, line_capture_gain});
    chk("mic_cap", {10'h000, cap_mic(m[2], m[3])}, {10'h000, mic_capture_gain});
    chk("select", {13'h0000, m[3][4], m[3][4], m[3][2]},
        {13'h0000, line_input_second, line_adc_second, mic_amplifier_on});
    chk("mode", {11'h000, m[4][4:0]}, {11'h000, mode_seen});
    chk("levels", {m[0], m[5]}, {reference_trim_code, aux_output_code});
  endtask : outs
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    void'($urandom(29));
    foreach (m[i]) m[i] = 8'h00;
    m[0] = 8'hA0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    outs();
    for (int i = 0; i < 7; i++) rd(i);
    for (int c = 0; c < 4; c++) begin
      wr(1, {c[1:0], 6'h3F});
      wr(2, {~c[1:0], 6'h00});
      outs();
    end
    wr(3, 8'hFF);
    outs();
    wr(3, 8'h04);
    outs();
    for (int k = 0; k < 80; k++) begin
      wr($urandom % 7, 8'($urandom));
      outs();
      rd($urandom % 7);
    end
    stop_test();
  end
  // Hang guard counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule : codec_gain_and_vref_control_test
`default_nettype wire
